//--- rtl/smacr_pkg.sv
package smacr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // register addresses
  localparam logic [7:0] BLEED_READBACK_CTRL_ADDR = 8'h2a;
  localparam logic [7:0] MODULATOR_CTRL_ADDR      = 8'h2b;
  localparam logic [7:0] CORE_D_AMPLITUDE_ADDR    = 8'h2c;
  localparam logic [7:0] CORE_C_AMPLITUDE_ADDR    = 8'h2d;
  localparam logic [7:0] CORE_B_AMPLITUDE_ADDR    = 8'h2e;
  localparam logic [7:0] CORE_A_REGULATOR_ADDR    = 8'h2f;
  localparam logic [7:0] FRAC_WORD_ADDR           = 8'h10;
  // reset values
  localparam logic [7:0] BLEED_READBACK_CTRL_RST  = 8'h00;
  localparam logic [7:0] MODULATOR_CTRL_RST       = 8'h01;
  localparam logic [7:0] CORE_D_AMPLITUDE_RST     = 8'h44;
  localparam logic [7:0] CORE_C_AMPLITUDE_RST     = 8'h11;
  localparam logic [7:0] CORE_B_AMPLITUDE_RST     = 8'h10;
  localparam logic [7:0] CORE_A_REGULATOR_RST     = 8'h92;
  // writable-bit masks, other bits reserved read-as-zero
  localparam logic [7:0] BLEED_READBACK_CTRL_MASK = 8'h29;
  localparam logic [7:0] MODULATOR_CTRL_MASK      = 8'h35;
  localparam logic [7:0] CORE_D_AMPLITUDE_MASK    = 8'h7f;
  localparam logic [7:0] CORE_CB_AMPLITUDE_MASK   = 8'h1f;
  localparam logic [7:0] CORE_A_REGULATOR_MASK    = 8'h9f;
  // field positions
  localparam int unsigned LEAKAGE_SIGN_BIT   = 5;
  localparam int unsigned LATCH_SOURCE_BIT   = 3;
  localparam int unsigned READBACK_SEL_BIT   = 0;
  localparam int unsigned HALF_STEP_BIT      = 5;
  localparam int unsigned AUX_MOD_BIT        = 4;
  localparam int unsigned RESET_MASK_BIT     = 2;
  localparam int unsigned BYPASS_BIT         = 0;
  localparam int unsigned D_RECT_BIT         = 6;
  localparam int unsigned D_LOW_BIT          = 5;
  localparam int unsigned D_NOM_LSB          = 2;
  localparam int unsigned TEMP_CAL_BIT       = 1;
  localparam int unsigned LOOP_OFF_BIT       = 0;
  localparam int unsigned CBA_RECT_BIT       = 4;
  localparam int unsigned CBA_LOW_BIT        = 3;
  localparam int unsigned CBA_NOM_LSB        = 0;
  localparam int unsigned REGULATOR_BIT      = 7;
  localparam int unsigned NOM_W              = 3;
  localparam int unsigned CORES              = 4;
endpackage : smacr_pkg

//--- rtl/smacr_regs.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Function
// - bleed sign bit: 0 negative, 1 positive
// - readback select: 0 vco data, 1 version
// - half step adds to fraction, aux off
// - fraction word write resets modulator unless masked
// - bypass bit resets 1, disables modulator
// - loop off bit disables amplitude loop
// - temp cal bit enables calibration voltage
// - rectifier bias per core, resets 1
// - low threshold per core, resets 0
// - regulator supply bit, resets 5 V
// - six registers load documented defaults
module smacr_regs
  import smacr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [smacr_pkg::ADDR_W-1:0] addr,
  input  wire logic [smacr_pkg::DATA_W-1:0] wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic [smacr_pkg::DATA_W-1:0]      rdata,
  output logic                       leakage_current_sign,
  output logic                       latch_source_reserved,
  output logic                       readback_version_sel,
  output logic                       frac_half_step,
  output logic                       aux_modulator_on,
  output logic                       modulator_reset_mask,
  output logic                       modulator_bypass,
  output logic                       modulator_reset,
  output logic                       amplitude_loop_off,
  output logic                       temp_cal_voltage_on,
  output logic [smacr_pkg::CORES-1:0]       rectifier_bias,
  output logic [smacr_pkg::CORES-1:0]       low_threshold,
  output logic [smacr_pkg::NOM_W-1:0]       core_d_nominal_threshold,
  output logic [smacr_pkg::NOM_W-1:0]       core_c_nominal_threshold,
  output logic [smacr_pkg::NOM_W-1:0]       core_b_nominal_threshold,
  output logic [smacr_pkg::NOM_W-1:0]       core_a_nominal_threshold,
  output logic                       regulator_supply_select
);
  import smacr_pkg::*;

  logic [7:0] bleed_readback_ctrl_reg;
  logic [7:0] modulator_ctrl_reg;
  logic [7:0] core_d_amplitude_ctrl_reg;
  logic [7:0] core_c_amplitude_ctrl_reg;
  logic [7:0] core_b_amplitude_ctrl_reg;
  logic [7:0] core_a_amplitude_regulator_ctrl_reg;
  logic       modulator_reset_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] core_ctrl [CORES];
  logic       addr_mapped;

  // one image per core so the per-core slicing below is a single loop
  assign core_ctrl[0] = core_d_amplitude_ctrl_reg;
  assign core_ctrl[1] = core_c_amplitude_ctrl_reg;
  assign core_ctrl[2] = core_b_amplitude_ctrl_reg;
  assign core_ctrl[3] = core_a_amplitude_regulator_ctrl_reg;

  // address decode used by the checks on unmapped places
  assign addr_mapped = (addr == BLEED_READBACK_CTRL_ADDR) || (addr == MODULATOR_CTRL_ADDR)
                       || (addr == CORE_D_AMPLITUDE_ADDR) || (addr == CORE_C_AMPLITUDE_ADDR)
                       || (addr == CORE_B_AMPLITUDE_ADDR) || (addr == CORE_A_REGULATOR_ADDR);

  // register writes; reserved bits masked so they stay zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bleed_readback_ctrl_reg             <= BLEED_READBACK_CTRL_RST;
      modulator_ctrl_reg                  <= MODULATOR_CTRL_RST;
      core_d_amplitude_ctrl_reg           <= CORE_D_AMPLITUDE_RST;
      core_c_amplitude_ctrl_reg           <= CORE_C_AMPLITUDE_RST;
      core_b_amplitude_ctrl_reg           <= CORE_B_AMPLITUDE_RST;
      core_a_amplitude_regulator_ctrl_reg <= CORE_A_REGULATOR_RST;
    end
    else if (wr_en)
    begin
      case (addr)
        BLEED_READBACK_CTRL_ADDR: bleed_readback_ctrl_reg <= wdata & BLEED_READBACK_CTRL_MASK;
        MODULATOR_CTRL_ADDR:      modulator_ctrl_reg <= wdata & MODULATOR_CTRL_MASK;
        CORE_D_AMPLITUDE_ADDR:    core_d_amplitude_ctrl_reg <= wdata & CORE_D_AMPLITUDE_MASK;
        CORE_C_AMPLITUDE_ADDR:    core_c_amplitude_ctrl_reg <= wdata & CORE_CB_AMPLITUDE_MASK;
        CORE_B_AMPLITUDE_ADDR:    core_b_amplitude_ctrl_reg <= wdata & CORE_CB_AMPLITUDE_MASK;
        CORE_A_REGULATOR_ADDR:    core_a_amplitude_regulator_ctrl_reg <= wdata & CORE_A_REGULATOR_MASK;
        default:                  ;
      endcase
    end
  end

  // fraction word write pulses a modulator reset, one cycle, unless masked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      modulator_reset_reg <= 1'b0;
    else
      modulator_reset_reg <= wr_en && (addr == FRAC_WORD_ADDR)
                             && !modulator_ctrl_reg[RESET_MASK_BIT];
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = '0;
    case (addr)
      BLEED_READBACK_CTRL_ADDR: rdata_next = bleed_readback_ctrl_reg;
      MODULATOR_CTRL_ADDR:      rdata_next = modulator_ctrl_reg;
      CORE_D_AMPLITUDE_ADDR:    rdata_next = core_d_amplitude_ctrl_reg;
      CORE_C_AMPLITUDE_ADDR:    rdata_next = core_c_amplitude_ctrl_reg;
      CORE_B_AMPLITUDE_ADDR:    rdata_next = core_b_amplitude_ctrl_reg;
      CORE_A_REGULATOR_ADDR:    rdata_next = core_a_amplitude_regulator_ctrl_reg;
      default:                  rdata_next = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= '0;
    else if (rd_en)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= '0;
  end

  assign rdata                 = rdata_reg;
  assign modulator_reset       = modulator_reset_reg;
  // control fields straight from their flops
  assign leakage_current_sign  = bleed_readback_ctrl_reg[LEAKAGE_SIGN_BIT];
  assign latch_source_reserved = bleed_readback_ctrl_reg[LATCH_SOURCE_BIT];
  assign readback_version_sel  = bleed_readback_ctrl_reg[READBACK_SEL_BIT];
  // half step only meaningful with aux modulator off; consumer gates it
  assign frac_half_step        = modulator_ctrl_reg[HALF_STEP_BIT];
  assign aux_modulator_on      = modulator_ctrl_reg[AUX_MOD_BIT];
  assign modulator_reset_mask  = modulator_ctrl_reg[RESET_MASK_BIT];
  assign modulator_bypass      = modulator_ctrl_reg[BYPASS_BIT];
  assign amplitude_loop_off    = core_d_amplitude_ctrl_reg[LOOP_OFF_BIT];
  assign temp_cal_voltage_on   = core_d_amplitude_ctrl_reg[TEMP_CAL_BIT];
  // nominal thresholds stored as written; software picks the codes
  assign core_d_nominal_threshold = core_d_amplitude_ctrl_reg[D_NOM_LSB +: NOM_W];
  assign core_c_nominal_threshold = core_c_amplitude_ctrl_reg[CBA_NOM_LSB +: NOM_W];
  assign core_b_nominal_threshold = core_b_amplitude_ctrl_reg[CBA_NOM_LSB +: NOM_W];
  assign core_a_nominal_threshold = core_a_amplitude_regulator_ctrl_reg[CBA_NOM_LSB +: NOM_W];
  assign regulator_supply_select  = core_a_amplitude_regulator_ctrl_reg[REGULATOR_BIT];
  // per-core bias/threshold, index 0 = core d .. 3 = core a
  for (genvar core = 0; core < CORES; core++)
  begin : g_core
    // core d keeps its fields higher up, as it shares the register with loop controls
    localparam int unsigned RECT_POS = (core == 0) ? D_RECT_BIT : CBA_RECT_BIT;
    localparam int unsigned LOW_POS  = (core == 0) ? D_LOW_BIT : CBA_LOW_BIT;
    assign rectifier_bias[core] = core_ctrl[core][RECT_POS];
    assign low_threshold[core]  = core_ctrl[core][LOW_POS];
  end

  a_frac_reset_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == FRAC_WORD_ADDR && !modulator_ctrl_reg[RESET_MASK_BIT]) |=> modulator_reset)
    else $error("fraction write did not reset modulator");
  a_frac_reset_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == FRAC_WORD_ADDR && modulator_ctrl_reg[RESET_MASK_BIT]) |=> !modulator_reset)
    else $error("masked fraction write reset modulator");
  a_reserved_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
    ((bleed_readback_ctrl_reg & ~BLEED_READBACK_CTRL_MASK) == 8'h00)
    && ((modulator_ctrl_reg & ~MODULATOR_CTRL_MASK) == 8'h00))
    else $error("reserved bit set");
  a_reset_defaults: assert property (@(posedge clk)
    !rst_n |=> (modulator_ctrl_reg == MODULATOR_CTRL_RST && core_a_amplitude_regulator_ctrl_reg == CORE_A_REGULATOR_RST
               && core_d_amplitude_ctrl_reg == CORE_D_AMPLITUDE_RST))
    else $error("reset default wrong");
  a_bypass_after_reset: assert property (@(posedge clk)
    !rst_n |=> modulator_bypass)
    else $error("bypass not set after reset");
  a_bias_write_track: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_D_AMPLITUDE_ADDR) |=> (rectifier_bias[0] == $past(wdata[D_RECT_BIT])
      && amplitude_loop_off == $past(wdata[LOOP_OFF_BIT]) && temp_cal_voltage_on == $past(wdata[TEMP_CAL_BIT])))
    else $error("core d field not stored");
  a_low_thr_track: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_A_REGULATOR_ADDR) |=> (low_threshold[3] == $past(wdata[CBA_LOW_BIT])
      && regulator_supply_select == $past(wdata[REGULATOR_BIT])))
    else $error("core a field not stored");
  a_sign_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == BLEED_READBACK_CTRL_ADDR) |=> (leakage_current_sign == $past(wdata[LEAKAGE_SIGN_BIT])
      && readback_version_sel == $past(wdata[READBACK_SEL_BIT])))
    else $error("bleed sign or readback select not stored");
  a_read_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_en |=> (rdata == 8'h00))
    else $error("read data outside read cycle");

  // reset defaults for the registers the check above leaves out
  a_reset_bleed_cores: assert property (@(posedge clk)
    !rst_n |=> (bleed_readback_ctrl_reg == BLEED_READBACK_CTRL_RST
               && core_c_amplitude_ctrl_reg == CORE_C_AMPLITUDE_RST
               && core_b_amplitude_ctrl_reg == CORE_B_AMPLITUDE_RST))
    else $error("reset default wrong on bleed or core c or b");
  // pulses and read data must be quiet straight out of reset
  a_reset_pulse_quiet: assert property (@(posedge clk)
    !rst_n |=> (!modulator_reset && rdata == 8'h00))
    else $error("pulse or read data active after reset");
  // a modulator reset only ever follows a fraction word write
  a_pulse_has_cause: assert property (@(posedge clk) disable iff (!rst_n)
    modulator_reset |-> ($past(wr_en) && $past(addr) == FRAC_WORD_ADDR))
    else $error("modulator reset without fraction write");
  // the fraction word lives elsewhere; a write to it must not touch the modulator or bleed controls
  a_frac_write_no_store: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == FRAC_WORD_ADDR) |=> ($stable(modulator_ctrl_reg) && $stable(bleed_readback_ctrl_reg)))
    else $error("fraction write changed a control register");
  a_mod_write_track: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == MODULATOR_CTRL_ADDR) |=> (frac_half_step == $past(wdata[HALF_STEP_BIT])
      && aux_modulator_on == $past(wdata[AUX_MOD_BIT]) && modulator_reset_mask == $past(wdata[RESET_MASK_BIT])
      && modulator_bypass == $past(wdata[BYPASS_BIT])))
    else $error("modulator control field not stored");
  a_core_c_track: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_C_AMPLITUDE_ADDR) |=> (rectifier_bias[1] == $past(wdata[CBA_RECT_BIT])
      && low_threshold[1] == $past(wdata[CBA_LOW_BIT])
      && core_c_nominal_threshold == $past(wdata[CBA_NOM_LSB +: NOM_W])))
    else $error("core c field not stored");
  a_core_b_track: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_B_AMPLITUDE_ADDR) |=> (rectifier_bias[2] == $past(wdata[CBA_RECT_BIT])
      && low_threshold[2] == $past(wdata[CBA_LOW_BIT])
      && core_b_nominal_threshold == $past(wdata[CBA_NOM_LSB +: NOM_W])))
    else $error("core b field not stored");
  a_core_d_nominal: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_D_AMPLITUDE_ADDR) |=> (low_threshold[0] == $past(wdata[D_LOW_BIT])
      && core_d_nominal_threshold == $past(wdata[D_NOM_LSB +: NOM_W])))
    else $error("core d threshold not stored");
  a_core_a_rect_nom: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == CORE_A_REGULATOR_ADDR) |=> (rectifier_bias[3] == $past(wdata[CBA_RECT_BIT])
      && core_a_nominal_threshold == $past(wdata[CBA_NOM_LSB +: NOM_W])))
    else $error("core a bias or threshold not stored");
  // the reserved read-write bit is plain storage
  a_latch_stored: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && addr == BLEED_READBACK_CTRL_ADDR) |=> (latch_source_reserved == $past(wdata[LATCH_SOURCE_BIT])))
    else $error("reserved read-write bit not stored");
  a_reserved_core_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ((core_d_amplitude_ctrl_reg & ~CORE_D_AMPLITUDE_MASK) == 8'h00)
    && ((core_c_amplitude_ctrl_reg & ~CORE_CB_AMPLITUDE_MASK) == 8'h00)
    && ((core_b_amplitude_ctrl_reg & ~CORE_CB_AMPLITUDE_MASK) == 8'h00)
    && ((core_a_amplitude_regulator_ctrl_reg & ~CORE_A_REGULATOR_MASK) == 8'h00))
    else $error("reserved core bit set");
  // writes to places outside the bank are dropped
  a_unmapped_no_store: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && !addr_mapped) |=> ($stable(bleed_readback_ctrl_reg) && $stable(modulator_ctrl_reg)
      && $stable(core_d_amplitude_ctrl_reg) && $stable(core_c_amplitude_ctrl_reg)
      && $stable(core_b_amplitude_ctrl_reg) && $stable(core_a_amplitude_regulator_ctrl_reg)))
    else $error("unmapped write changed a register");
  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_en && !addr_mapped) |=> (rdata == 8'h00))
    else $error("unmapped read returned data");
  a_read_modulator: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_en && addr == MODULATOR_CTRL_ADDR) |=> (rdata == $past(modulator_ctrl_reg)))
    else $error("modulator control read back wrong");
  a_read_regulator: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_en && addr == CORE_A_REGULATOR_ADDR) |=> (rdata == $past(core_a_amplitude_regulator_ctrl_reg)))
    else $error("regulator register read back wrong");
  // without a write the modulator and core a regulator controls must hold still
  a_hold_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_en |=> ($stable(modulator_ctrl_reg) && $stable(core_a_amplitude_regulator_ctrl_reg)))
    else $error("control register changed without a write");
endmodule : smacr_regs
`default_nettype wire

//--- tb/smacr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module smacr_regs_tb;
  import smacr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  rdata;
  logic        sign, latch, rbsel, half, aux, mmask, bypass, mreset, loopoff, tcal, regsel;
  logic [3:0]  rect, lowt;
  logic [2:0]  nd, nc, nb, na;
  logic [29:0] outs;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  // address table and expected images, same order everywhere
  logic [7:0]  regs [6] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
  logic [7:0]  rst_v [6] = '{8'h00, 8'h01, 8'h44, 8'h11, 8'h10, 8'h92};
  logic [7:0]  ones_v [6] = '{8'h29, 8'h35, 8'h7f, 8'h1f, 8'h1f, 8'h9f};
  logic [7:0]  pat_v [6] = '{8'h08, 8'h21, 8'h61, 8'h0a, 8'h15, 8'h83};
  // every control output but the modulator reset pulse in one word so a swapped bit shows up
  assign outs = {sign, latch, rbsel, half, aux, mmask, bypass, loopoff, tcal, regsel, rect, lowt, nd, nc, nb, na};
  smacr_regs dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .leakage_current_sign(sign), .latch_source_reserved(latch), .readback_version_sel(rbsel),
    .frac_half_step(half), .aux_modulator_on(aux), .modulator_reset_mask(mmask), .modulator_bypass(bypass),
    .modulator_reset(mreset), .amplitude_loop_off(loopoff), .temp_cal_voltage_on(tcal),
    .rectifier_bias(rect), .low_threshold(lowt), .core_d_nominal_threshold(nd),
    .core_c_nominal_threshold(nc), .core_b_nominal_threshold(nb), .core_a_nominal_threshold(na),
    .regulator_supply_select(regsel));
  // 250 MHz clock
  always #2 clk = ~clk;
  // hang guard, the whole run needs about a hundred and ten cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one-cycle strobes, outputs settle before the caller looks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask : rd
  task automatic rd_all(input logic [7:0] v [6]);
    for (int i = 0; i < 6; i++) rd(regs[i], v[i]);
  endtask : rd_all
  task automatic wr_all(input logic [7:0] v [6]);
    for (int i = 0; i < 6; i++) wr(regs[i], v[i]);
  endtask : wr_all
  task automatic t_reset();
    rd_all(rst_v);
    cmp(outs, {10'b0000001001, 4'hf, 4'h0, 12'b001001000010});
    cmp(mreset, 1'b0);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_ones();
    wr_all('{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    cmp(outs, 30'h3fffffff);
    rd_all(ones_v);
    $display("test all ones done");
  endtask : t_ones
  task automatic t_pattern();
    wr_all(pat_v);
    cmp(outs, {10'b0101001101, 4'b0101, 4'b0011, 12'b000010101011});
    rd_all(pat_v);
    $display("test mixed pattern done");
  endtask : t_pattern
  // unmapped places neither store nor disturb anything
  task automatic t_unmapped();
    wr(8'h30, 8'hff);
    wr(8'h29, 8'hff);
    cmp(outs, {10'b0101001101, 4'b0101, 4'b0011, 12'b000010101011});
    rd(8'h30, 8'h00);
    rd(8'h10, 8'h00);
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_sdreset();
    wr(8'h2b, 8'h00);
    wr(8'h10, 8'h5a);
    cmp(mreset, 1'b1);
    @(posedge clk);
    #1;
    cmp(mreset, 1'b0);
    wr(8'h2b, 8'h04);
    wr(8'h10, 8'h5a);
    cmp(mreset, 1'b0);
    $display("test modulator reset done");
  endtask : t_sdreset
  // software side: aux modulator on with bypass off, nominal threshold codes
  task automatic t_software();
    wr(8'h2b, 8'h10);
    cmp({aux, bypass}, 2'b10);
    wr(8'h2d, 8'h02);
    cmp(nc, 3'h2);
    wr(8'h2e, 8'h00);
    cmp(nb, 3'h0);
    wr(8'h2c, 8'h04);
    cmp(nd, 3'h1);
    wr(8'h2f, 8'h82);
    cmp(na, 3'h2);
    $display("test software settings done");
  endtask : t_software
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // main sequence, with a second reset before the last check
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ones();
    t_pattern();
    t_unmapped();
    t_sdreset();
    t_software();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    finish_test();
  end
endmodule : smacr_regs_tb
`default_nettype wire
